//--- rtl/gotm_regs.svh
// Purpose: word offsets, field values and reset values of the gateway area
// Assumes: offsets are word addresses on the register port
// Notes: definitions only
`ifndef GOTM_REGS_SVH
`define GOTM_REGS_SVH
`define GOTM_USER_BASE 16'h0000
`define GOTM_USER_LAST 16'h01f3
`define GOTM_RESET_OFS 16'h01f4
`define GOTM_POLL_OFS 16'h01f5
`define GOTM_TRIG_OFS 16'h01f6
`define GOTM_CNT_OFS 16'h047e
`define GOTM_ERR_OFS 16'h047f
`define GOTM_RLEN_OFS 16'h0480
`define GOTM_RBUF_BASE 16'h0481
`define GOTM_RBUF_LAST 16'h050e
`define GOTM_CHAN_OFS 16'h076c
`define GOTM_SLEN_OFS 16'h076d
`define GOTM_SBUF_BASE 16'h076e
`define GOTM_SBUF_LAST 16'h07fb
`define GOTM_IDX_THROUGH 8'hff
`define GOTM_IDX_USER_MAX 8'h63
`define GOTM_POLL_ON 8'h01
`define GOTM_CHAN_THROUGH 8'h00
`define GOTM_ERR_IDX_RST 8'hff
`define GOTM_REG_RST 16'h0000
`define GOTM_BYTE_RST 8'h00
`define GOTM_USER_WORDS 500
`define GOTM_BUF_WORDS 142
`define GOTM_BUF_BYTES 9'h11c
`define GOTM_FIFO_DEPTH 16
`endif

//--- rtl/gotm_pkg.sv
// Purpose: shared types of the gateway output area
// Assumes: used with gotm_regs.svh
// Notes: one-hot state codes
package gotm_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FETCH = 5'h02,
    S_HI = 5'h04,
    S_LO = 5'h08,
    S_WAIT = 5'h10
  } gotm_state_t;

  // one byte of an outgoing frame
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } gotm_txb_t;

  // events from the command engine
  typedef struct packed {
    logic req;
    logic rsp;
    logic err;
    logic [7:0] status;
    logic [7:0] idx;
  } gotm_evt_t;

  typedef struct packed {
    logic [15:0] req_cnt;
    logic [15:0] rsp_cnt;
    logic [15:0] err_cnt;
    logic [7:0] err_status;
    logic [7:0] err_idx;
  } gotm_mod_t;
endpackage : gotm_pkg

//--- rtl/gotm_mem.sv
// Purpose: word memory, one write port, two registered read ports
// Assumes: single clock
// Notes: contents are not reset
`timescale 1ns/1ps
module gotm_mem #(
  parameter int W = 16,
  parameter int DEPTH = 142,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  output logic [W-1:0] o_rdata_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [W-1:0] o_rdata_b
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end
endmodule : gotm_mem

//--- rtl/gotm_fifo.sv
// Purpose: valid/ready fifo between frame reader and field link
// Assumes: single clock, async active-low reset
// Notes: out data shows the head entry while not empty
`timescale 1ns/1ps
module gotm_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : gotm_fifo

//--- rtl/gotm_top.sv
// Purpose: output word area and through-mode engine of the gateway
// Assumes: register port and link inputs synchronous to i_clk
// Notes: reads answer two cycles after i_rd
`timescale 1ns/1ps
`include "gotm_regs.svh"
module gotm_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_user_go,
  output logic [7:0] o_user_index,
  output logic o_auto_poll,
  output logic o_state_clear,
  input wire gotm_pkg::gotm_evt_t i_mod_evt,
  output gotm_pkg::gotm_mod_t o_mod_state,
  output logic o_tx_valid,
  output gotm_pkg::gotm_txb_t o_tx_data,
  input wire logic i_tx_ready,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_last,
  input wire logic i_rx_none
);
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic [7:0] rst_byte;
  logic [7:0] poll_byte;
  logic [15:0] trig;
  logic [7:0] chan_byte;
  logic [15:0] slen;
  logic wr_trig;
  logic trig_fire;
  logic wr_clear;
  logic through_go;
  gotm_pkg::gotm_state_t state;

  assign wr_trig = i_wr && (i_addr == `GOTM_TRIG_OFS);
  assign trig_fire = wr_trig && (i_wdata[7:0] != trig[7:0]);
  assign wr_clear = i_wr && (i_addr == `GOTM_RESET_OFS) &&
                    (i_wdata[7:0] != `GOTM_BYTE_RST);
  assign through_go = trig_fire &&
                      (i_wdata[15:8] == `GOTM_IDX_THROUGH) &&
                      (state == gotm_pkg::S_IDLE) &&
                      (poll_byte != `GOTM_POLL_ON) &&
                      (chan_byte == `GOTM_CHAN_THROUGH);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_byte <= `GOTM_BYTE_RST;
      poll_byte <= `GOTM_BYTE_RST;
      trig <= `GOTM_REG_RST;
      chan_byte <= `GOTM_BYTE_RST;
      slen <= `GOTM_REG_RST;
    end else if (i_wr) begin
      case (i_addr)
        `GOTM_RESET_OFS: rst_byte <= i_wdata[7:0];
        `GOTM_POLL_OFS: poll_byte <= i_wdata[7:0];
        `GOTM_TRIG_OFS: trig <= i_wdata;
        `GOTM_CHAN_OFS: chan_byte <= i_wdata[7:0];
        `GOTM_SLEN_OFS: slen <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command outputs and module state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_user_go <= 1'b0;
      o_user_index <= `GOTM_BYTE_RST;
      o_auto_poll <= 1'b0;
      o_state_clear <= 1'b0;
    end else begin
      o_user_go <= trig_fire &&
                   (i_wdata[15:8] <= `GOTM_IDX_USER_MAX);
      if (trig_fire) begin
        o_user_index <= i_wdata[15:8];
      end
      o_auto_poll <= (poll_byte == `GOTM_POLL_ON);
      o_state_clear <= wr_clear;
    end
  end

  // clear first, then any event of the same cycle still counts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mod_state <= '{16'h0000, 16'h0000, 16'h0000, 8'h00,
                       `GOTM_ERR_IDX_RST};
    end else begin
      o_mod_state.req_cnt <= (wr_clear ? 16'h0000 : o_mod_state.req_cnt)
                             + 16'(i_mod_evt.req);
      o_mod_state.rsp_cnt <= (wr_clear ? 16'h0000 : o_mod_state.rsp_cnt)
                             + 16'(i_mod_evt.rsp);
      o_mod_state.err_cnt <= (wr_clear ? 16'h0000 : o_mod_state.err_cnt)
                             + 16'(i_mod_evt.err);
      if (i_mod_evt.err) begin
        o_mod_state.err_status <= i_mod_evt.status;
        o_mod_state.err_idx <= i_mod_evt.idx;
      end else if (wr_clear) begin
        o_mod_state.err_status <= 8'h00;
        o_mod_state.err_idx <= `GOTM_ERR_IDX_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  logic [15:0] user_rd;
  logic [15:0] sbuf_rd;
  logic [15:0] sbuf_tx;
  logic [15:0] rbuf_rd;
  logic [7:0] widx;
  logic rx_we;
  logic [7:0] rx_waddr;
  logic [15:0] rx_wdata;
  logic [15:0] user_off;
  logic [15:0] sbuf_off;
  logic [15:0] rbuf_off;

  assign user_off = i_addr - `GOTM_USER_BASE;
  assign sbuf_off = i_addr - `GOTM_SBUF_BASE;
  assign rbuf_off = i_addr - `GOTM_RBUF_BASE;

  gotm_mem #(.W(16), .DEPTH(`GOTM_USER_WORDS)) u_user (
    .i_clk(i_clk),
    .i_we(i_wr && in_rng(i_addr, `GOTM_USER_BASE, `GOTM_USER_LAST)),
    .i_waddr(user_off[8:0]),
    .i_wdata(i_wdata),
    .i_raddr_a(user_off[8:0]),
    .o_rdata_a(user_rd),
    .i_raddr_b(9'h000),
    .o_rdata_b()
  );

  gotm_mem #(.W(16), .DEPTH(`GOTM_BUF_WORDS)) u_sbuf (
    .i_clk(i_clk),
    .i_we(i_wr && in_rng(i_addr, `GOTM_SBUF_BASE, `GOTM_SBUF_LAST)),
    .i_waddr(sbuf_off[7:0]),
    .i_wdata(i_wdata),
    .i_raddr_a(sbuf_off[7:0]),
    .o_rdata_a(sbuf_rd),
    .i_raddr_b(widx),
    .o_rdata_b(sbuf_tx)
  );

  gotm_mem #(.W(16), .DEPTH(`GOTM_BUF_WORDS)) u_rbuf (
    .i_clk(i_clk),
    .i_we(rx_we),
    .i_waddr(rx_waddr),
    .i_wdata(rx_wdata),
    .i_raddr_a(rbuf_off[7:0]),
    .o_rdata_a(rbuf_rd),
    .i_raddr_b(8'h00),
    .o_rdata_b()
  );

  // ----------------------------------------------------------------
  // through-mode transmit
  // ----------------------------------------------------------------
  logic [8:0] left;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic out_take;
  gotm_pkg::gotm_txb_t push_data;
  gotm_pkg::gotm_txb_t fifo_data;

  assign push = (state == gotm_pkg::S_HI) || (state == gotm_pkg::S_LO);
  assign push_data.last = (left == 9'h001);
  assign push_data.data = (state == gotm_pkg::S_HI) ? sbuf_tx[15:8]
                                                    : sbuf_tx[7:0];
  assign out_take = !o_tx_valid || i_tx_ready;

  gotm_fifo #(.W(9), .DEPTH(`GOTM_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(push_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(out_take),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= '0;
    end else if (out_take) begin
      o_tx_valid <= fifo_valid;
      o_tx_data <= fifo_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= gotm_pkg::S_IDLE;
      left <= 9'h000;
      widx <= 8'h00;
    end else begin
      case (state)
        gotm_pkg::S_IDLE: begin
          if (through_go) begin
            left <= (slen > 16'(`GOTM_BUF_BYTES)) ? `GOTM_BUF_BYTES
                                                 : slen[8:0];
            widx <= 8'h00;
            state <= (slen == 16'h0000) ? gotm_pkg::S_WAIT
                                        : gotm_pkg::S_FETCH;
          end
        end
        gotm_pkg::S_FETCH: state <= gotm_pkg::S_HI;
        gotm_pkg::S_HI: begin
          if (fifo_ready) begin
            left <= left - 9'h001;
            state <= push_data.last ? gotm_pkg::S_WAIT : gotm_pkg::S_LO;
          end
        end
        gotm_pkg::S_LO: begin
          if (fifo_ready) begin
            left <= left - 9'h001;
            widx <= widx + 8'h01;
            state <= push_data.last ? gotm_pkg::S_WAIT
                                    : gotm_pkg::S_FETCH;
          end
        end
        gotm_pkg::S_WAIT: begin
          if ((i_rx_valid && i_rx_last) || i_rx_none) begin
            state <= gotm_pkg::S_IDLE;
          end
        end
        default: state <= gotm_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // through-mode receive and counters
  // ----------------------------------------------------------------
  logic [8:0] rx_pos;
  logic [7:0] rx_hi;
  logic [7:0] rx_cnt;
  logic [7:0] tx_cnt;
  logic [7:0] err_cnt;
  logic [15:0] rx_len;
  logic rx_take;
  logic sent;

  assign rx_take = i_rx_valid && (state == gotm_pkg::S_WAIT);
  assign rx_we = rx_take && (rx_pos[0] || i_rx_last) &&
                 (rx_pos < `GOTM_BUF_BYTES);
  assign rx_waddr = rx_pos[8:1];
  assign rx_wdata = rx_pos[0] ? {rx_hi, i_rx_byte} : {i_rx_byte, 8'h00};
  assign sent = push && fifo_ready && push_data.last;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_pos <= 9'h000;
      rx_hi <= 8'h00;
      rx_len <= `GOTM_REG_RST;
    end else if (through_go) begin
      rx_pos <= 9'h000;
    end else if (rx_take) begin
      rx_pos <= rx_pos + 9'h001;
      if (!rx_pos[0]) begin
        rx_hi <= i_rx_byte;
      end
      if (i_rx_last) begin
        rx_len <= {7'h00, rx_pos} + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_cnt <= 8'h00;
      tx_cnt <= 8'h00;
      err_cnt <= 8'h00;
    end else begin
      if (rx_take && i_rx_last) begin
        rx_cnt <= rx_cnt + 8'h01;
      end
      if (sent || (through_go && slen == 16'h0000)) begin
        tx_cnt <= tx_cnt + 8'h01;
      end
      if (i_rx_none && state == gotm_pkg::S_WAIT) begin
        err_cnt <= err_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads, two cycles
  // ----------------------------------------------------------------
  logic rd_q;
  logic [15:0] addr_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= 1'b0;
      addr_q <= 16'h0000;
      o_rvalid <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      rd_q <= i_rd;
      addr_q <= i_addr;
      o_rvalid <= rd_q;
      if (!rd_q) begin
        o_rdata <= 16'h0000;
      end else if (in_rng(addr_q, `GOTM_USER_BASE, `GOTM_USER_LAST)) begin
        o_rdata <= user_rd;
      end else if (in_rng(addr_q, `GOTM_SBUF_BASE, `GOTM_SBUF_LAST)) begin
        o_rdata <= sbuf_rd;
      end else if (in_rng(addr_q, `GOTM_RBUF_BASE, `GOTM_RBUF_LAST)) begin
        o_rdata <= rbuf_rd;
      end else begin
        case (addr_q)
          `GOTM_RESET_OFS: o_rdata <= {8'h00, rst_byte};
          `GOTM_POLL_OFS: o_rdata <= {8'h00, poll_byte};
          `GOTM_TRIG_OFS: o_rdata <= trig;
          `GOTM_CHAN_OFS: o_rdata <= {8'h00, chan_byte};
          `GOTM_SLEN_OFS: o_rdata <= slen;
          `GOTM_CNT_OFS: o_rdata <= {rx_cnt, tx_cnt};
          `GOTM_ERR_OFS: o_rdata <= {8'h00, err_cnt};
          `GOTM_RLEN_OFS: o_rdata <= rx_len;
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_user_trig;
    trig_fire && (i_wdata[15:8] <= `GOTM_IDX_USER_MAX);
  endsequence
  sequence seq_frame_done;
    sent ##1 (state == gotm_pkg::S_WAIT);
  endsequence

  a_user_go_idx: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_user_trig |=> o_user_go && o_user_index == $past(i_wdata[15:8]))
    else $error("user trigger not issued");
  a_same_no_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_trig && i_wdata[7:0] == trig[7:0] |=> !o_user_go)
    else $error("repeated trigger value fired");
  a_go_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_user_go |-> o_user_index <= `GOTM_IDX_USER_MAX)
    else $error("user index out of range");
  a_clear_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_clear && !i_mod_evt.err |=> o_state_clear &&
      o_mod_state.err_idx == `GOTM_ERR_IDX_RST &&
      o_mod_state.err_status == 8'h00)
    else $error("module state not cleared");
  a_poll_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr && i_addr == `GOTM_POLL_OFS && i_wdata[7:0] == 8'h01
      |=> ##1 o_auto_poll)
    else $error("auto poll not enabled");
  a_frame_sent: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_frame_done |-> tx_cnt == $past(tx_cnt) + 8'h01)
    else $error("send count not bumped");
  a_rx_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_take && i_rx_last |=> rx_cnt == $past(rx_cnt) + 8'h01 &&
      rx_len == {7'h00, $past(rx_pos)} + 16'h0001 &&
      state == gotm_pkg::S_IDLE)
    else $error("receive not recorded");
  a_none_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rx_none && !i_rx_valid && state == gotm_pkg::S_WAIT
      |=> err_cnt == $past(err_cnt) + 8'h01 && $stable(rx_cnt))
    else $error("missing response not counted");
  a_cnt_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_take && i_rx_last && rx_cnt == 8'hff |=> rx_cnt == 8'h00)
    else $error("receive count did not wrap");
  a_cnt_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd && i_addr == `GOTM_CNT_OFS |-> ##2 o_rvalid &&
      o_rdata == {$past(rx_cnt), $past(tx_cnt)})
    else $error("count word read wrong");
endmodule : gotm_top

//--- verification/gotm_link_model.sv
// Purpose: field link model for the through-mode engine
// Assumes: bytes move on valid and ready at the rising edge
// Notes: stalls 24 cycles per frame, then accepts every other cycle
`timescale 1ns/1ps
module gotm_link_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_valid,
  input wire gotm_pkg::gotm_txb_t i_tx_data,
  input wire logic i_answer,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_last,
  output logic o_rx_none
);
  logic [7:0] cap [0:63];
  int ncap;
  int stall;
  int resp;
  logic done;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_ready <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
      o_rx_last <= 1'b0;
      o_rx_none <= 1'b0;
      ncap <= 0;
      stall <= 0;
      resp <= 0;
      done <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_last <= 1'b0;
      o_rx_none <= 1'b0;
      // idle data line keeps moving
      o_rx_byte <= ~o_rx_byte;
      if (i_tx_valid && stall < 24) begin
        stall <= stall + 1;
      end
      o_tx_ready <= (stall >= 24) && !o_tx_ready;
      if (i_tx_valid && o_tx_ready) begin
        // a new frame restarts the capture
        cap[done ? 0 : ncap] <= i_tx_data.data;
        ncap <= done ? 1 : ncap + 1;
        done <= i_tx_data.last;
        if (i_tx_data.last) begin
          resp <= 1;
          stall <= 0;
        end
      end
      if (resp > 0) begin
        resp <= resp + 1;
        if (resp == 4 && i_answer) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= 8'hab;
        end else if (resp == 5 && i_answer) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= 8'hcd;
          o_rx_last <= 1'b1;
          resp <= 0;
        end else if (resp == 4) begin
          o_rx_none <= 1'b1;
          resp <= 0;
        end
      end
    end
  end
endmodule : gotm_link_model

//--- verification/testbench.sv
// Purpose: self-checking bench of the gateway output area
// Assumes: inputs driven at the falling edge
// Notes: link side is played by gotm_link_model
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata;
  logic o_rvalid, o_user_go, o_auto_poll, o_state_clear, o_tx_valid;
  logic [7:0] o_user_index;
  gotm_pkg::gotm_evt_t i_mod_evt = '0;
  gotm_pkg::gotm_mod_t o_mod_state;
  gotm_pkg::gotm_txb_t o_tx_data;
  logic tx_ready, rx_valid, rx_last, rx_none;
  logic [7:0] rx_byte;
  logic answer = 1'b1;
  int errors = 0;
  int comparisons = 0;
  int gos = 0;
  int clears = 0;
  int cyc = 0;

  gotm_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_user_go(o_user_go),
    .o_user_index(o_user_index), .o_auto_poll(o_auto_poll),
    .o_state_clear(o_state_clear), .i_mod_evt(i_mod_evt),
    .o_mod_state(o_mod_state), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .i_rx_last(rx_last), .i_rx_none(rx_none));

  gotm_link_model link_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_answer(answer),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
    .o_rx_last(rx_last), .o_rx_none(rx_none));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (o_user_go === 1'b1) gos++;
    if (o_state_clear === 1'b1) clears++;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
    @(negedge i_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int k;
    d = 16'hxxxx;
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    for (k = 0; k < 4; k++) begin
      @(posedge i_clk);
      #1;
      if (o_rvalid === 1'b1) begin
        d = o_rdata;
        break;
      end
    end
    @(negedge i_clk);
  endtask : rd

  task automatic rc(input logic [15:0] a, input logic [15:0] e,
                    input string n);
    logic [15:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask : rc

  task automatic t_state_reset();
    i_mod_evt = '{req: 1'b1, rsp: 1'b1, err: 1'b1, status: 8'h5a,
                  idx: 8'h07};
    @(negedge i_clk);
    i_mod_evt = '0;
    @(negedge i_clk);
    chk("req_cnt", 16'h0001, o_mod_state.req_cnt);
    chk("rsp_cnt", 16'h0001, o_mod_state.rsp_cnt);
    chk("err_idx", 16'h0007, {8'h00, o_mod_state.err_idx});
    wr(16'h01f4, 16'h0001);
    @(negedge i_clk);
    chk("clears", 16'h0001, clears[15:0]);
    chk("req_cnt", 16'h0000, o_mod_state.req_cnt);
    chk("rsp_cnt", 16'h0000, o_mod_state.rsp_cnt);
    chk("err_cnt", 16'h0000, o_mod_state.err_cnt);
    chk("err_status", 16'h0000, {8'h00, o_mod_state.err_status});
    chk("err_idx", 16'h00ff, {8'h00, o_mod_state.err_idx});
    wr(16'h01f4, 16'h0000);
    $display("test state_reset done");
  endtask : t_state_reset

  task automatic t_auto_poll();
    wr(16'h01f5, 16'h0001);
    @(negedge i_clk);
    chk("auto_poll", 16'h0001, {15'h0, o_auto_poll});
    wr(16'h01f5, 16'h0000);
    @(negedge i_clk);
    chk("auto_poll", 16'h0000, {15'h0, o_auto_poll});
    $display("test auto_poll done");
  endtask : t_auto_poll

  task automatic t_trigger();
    wr(16'h01f6, 16'h0501);
    @(negedge i_clk);
    chk("gos", 16'h0001, gos[15:0]);
    chk("user_index", 16'h0005, {8'h00, o_user_index});
    wr(16'h01f6, 16'h0501);
    wr(16'h01f6, 16'h6402);
    @(negedge i_clk);
    chk("gos", 16'h0001, gos[15:0]);
    wr(16'h0003, 16'h1234);
    rc(16'h0003, 16'h1234, "user word");
    rc(16'h01f6, 16'h6402, "trigger word");
    $display("test trigger done");
  endtask : t_trigger

  task automatic through(input logic [15:0] trig, input logic [15:0] len,
                         input logic [15:0] exp_cnt);
    logic [15:0] old_c, old_e, v, w;
    int k;
    wr(16'h076c, 16'h0000);
    wr(16'h076d, len);
    for (k = 0; k < 10; k++) begin
      wr(16'h076e + k[15:0], {8'h10 + 8'(2 * k), 8'h11 + 8'(2 * k)});
    end
    wr(16'h01f5, 16'h0000);
    rd(16'h047e, old_c);
    rd(16'h047f, old_e);
    wr(16'h01f6, trig);
    for (k = 0; k < 300; k++) begin
      rd(16'h047e, v);
      rd(16'h047f, w);
      if (v[15:8] !== old_c[15:8] || w[7:0] !== old_e[7:0]) break;
    end
    chk("sent bytes", len, link_u.ncap[15:0]);
    for (k = 0; k < int'(len); k++) begin
      chk("sent byte", {8'h00, 8'h10 + 8'(k)}, {8'h00, link_u.cap[k]});
    end
    rc(16'h047e, exp_cnt, "counts");
  endtask : through

  task automatic t_through_ok();
    answer = 1'b1;
    through(16'hff03, 16'h0014, 16'h0101);
    rc(16'h0480, 16'h0002, "rx_len");
    rc(16'h0481, 16'habcd, "rx_data");
    rc(16'h076e, 16'h1011, "send word");
    $display("test through_ok done");
  endtask : t_through_ok

  task automatic t_through_none();
    answer = 1'b0;
    through(16'hff04, 16'h0001, 16'h0102);
    rc(16'h047f, 16'h0001, "err_cnt");
    $display("test through_none done");
  endtask : t_through_none

  task automatic t_count_wrap();
    int n;
    answer = 1'b1;
    for (n = 0; n < 255; n++) begin
      through({8'hff, 8'(n + 5)}, 16'h0001, {8'(n + 2), 8'(n + 3)});
    end
    $display("test count_wrap done");
  endtask : t_count_wrap

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    rc(16'h047e, 16'h0000, "counts reset");
    chk("err_idx reset", 16'h00ff, {8'h00, o_mod_state.err_idx});
    t_state_reset();
    t_auto_poll();
    t_trigger();
    t_through_ok();
    t_through_none();
    t_count_wrap();
    complete_run();
  end
endmodule : testbench
